// File: common/dco_pkg.sv
// Constants and types shared by the decrement and complement execute logic.
// Assumes a core that presents one 14-bit instruction word per instruction cycle.
package dco_pkg;
	// ----------------------------------------------------------------
	// Instruction word layout
	// ----------------------------------------------------------------
	localparam int          INSN_W        = 14;
	localparam int          DATA_W        = 8;
	localparam int          ADDR_W        = 7;
	localparam int          OPC_HI        = 13;
	localparam int          OPC_LO        = 8;
	localparam int          TGT_BIT       = 7;
	localparam logic [5:0]  OPC_DEC       = 6'h03;
	localparam logic [5:0]  OPC_COM       = 6'h09;
	localparam logic [5:0]  OPC_DEC_SKIP  = 6'h0B;
	// ----------------------------------------------------------------
	// Reset values and the decrement step
	// ----------------------------------------------------------------
	localparam logic [7:0]  ACC_RESET     = 8'h00;
	localparam logic        ZERO_RESET    = 1'b0;
	localparam logic [7:0]  ONE_BYTE      = 8'h01;

	typedef enum logic [1:0] {
		DCO_OP_NONE,
		DCO_OP_DEC,
		DCO_OP_COM,
		DCO_OP_DEC_SKIP
	} dco_op_t;
endpackage

// File: design/dco_decode.sv
// Instruction decoder for the three register-file operations.
// Assumes a stable instruction word from the core fetch stage.
`timescale 1ns/100ps
`default_nettype none
module dco_decode (
	input  wire logic [dco_pkg::INSN_W-1:0] insn,
	output dco_pkg::dco_op_t                 op,
	output logic                             to_file,
	output logic [dco_pkg::ADDR_W-1:0]      file_addr
);
	import dco_pkg::*;

	// Upper six bits select the operation; low byte holds target and address.
	always_comb begin
		op = DCO_OP_NONE;
		if (insn[OPC_HI:OPC_LO] == OPC_COM) begin
			op = DCO_OP_COM;
		end else if (insn[OPC_HI:OPC_LO] == OPC_DEC_SKIP) begin
			op = DCO_OP_DEC_SKIP;
		end else if (insn[OPC_HI:OPC_LO] == OPC_DEC) begin
			op = DCO_OP_DEC;
		end
	end

	assign to_file   = insn[TGT_BIT];
	assign file_addr = insn[ADDR_W-1:0];
endmodule
`default_nettype wire

// File: design/dco_exec.sv
// Execute stage for decrement, complement and decrement-with-skip.
// Assumes the file register read data is valid in the same cycle as the word.
// Assumes the core leaves one slot free after a file-target word, as read and write share one address.
// Reset is synchronous and active high; it clears the idle slot and any pending write.
`timescale 1ns/100ps
`default_nettype none
module dco_exec (
	input  wire logic                        clk,
	input  wire logic                        reset,
	input  wire logic                        insn_valid,
	input  wire logic [dco_pkg::INSN_W-1:0]  insn,
	input  wire logic [dco_pkg::DATA_W-1:0]  file_rdata,
	output logic [dco_pkg::ADDR_W-1:0]       file_addr,
	output logic                             file_we,
	output logic [dco_pkg::DATA_W-1:0]       file_wdata,
	output logic [dco_pkg::DATA_W-1:0]       acc,
	output logic                             zero_flag,
	output logic                             idle_slot,
	output logic                             busy
);
	import dco_pkg::*;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Fields of the word currently on the instruction input.
	dco_op_t            op;
	logic               to_file;
	logic [ADDR_W-1:0]  dec_addr;

	// Combinational decoder for the current word.
	dco_decode u_decode (
		.insn      (insn),
		.op        (op),
		.to_file   (to_file),
		.file_addr (dec_addr)
	);

	// Decrement by one, wrapping through zero.
	function automatic logic [DATA_W-1:0] dec_byte(input logic [DATA_W-1:0] v);
		dec_byte = v - ONE_BYTE;
	endfunction

	// ----------------------------------------------------------------
	// Execute state
	// ----------------------------------------------------------------
	// Registered execute state, its next values and the shared result.
	logic [DATA_W-1:0]  acc_r, acc_nxt;
	logic               zero_r, zero_nxt;
	logic               skip_r, skip_nxt;
	logic [DATA_W-1:0]  wdata_r, wdata_nxt;
	logic               we_r, we_nxt;
	logic [ADDR_W-1:0]  addr_r, addr_nxt;
	logic               exec;
	logic [DATA_W-1:0]  result;

	// A word arriving during the idle slot is the discarded one.
	assign exec = insn_valid && !skip_r;

	// Next-state computation for accumulator, zero flag, write port and skip.
	always_comb begin
		acc_nxt   = acc_r;
		zero_nxt  = zero_r;
		skip_nxt  = 1'b0;
		wdata_nxt = wdata_r;
		we_nxt    = 1'b0;
		addr_nxt  = addr_r;
		result    = dec_byte(file_rdata);
		if (exec) begin
			// The decrement is the default result; complement replaces it.
			case (op)
				DCO_OP_COM: begin
					result   = ~file_rdata;
					zero_nxt = (result == '0);
				end
				DCO_OP_DEC: begin
					zero_nxt = (result == '0);
				end
				DCO_OP_DEC_SKIP: begin
					skip_nxt = (result == '0);
				end
				default: begin
					result = file_rdata;
				end
			endcase
			// Route the result by the target bit; a file write goes out one cycle later.
			if (op != DCO_OP_NONE) begin
				if (to_file) begin
					we_nxt    = 1'b1;
					wdata_nxt = result;
					addr_nxt  = dec_addr;
				end else begin
					acc_nxt = result;
				end
			end
		end
	end

	// Registers for the execute state.
	always_ff @(posedge clk) begin
		if (reset) begin
			acc_r   <= ACC_RESET;
			zero_r  <= ZERO_RESET;
			skip_r  <= 1'b0;
			wdata_r <= '0;
			we_r    <= 1'b0;
			addr_r  <= '0;
		end else begin
			acc_r   <= acc_nxt;
			zero_r  <= zero_nxt;
			skip_r  <= skip_nxt;
			wdata_r <= wdata_nxt;
			we_r    <= we_nxt;
			addr_r  <= addr_nxt;
		end
	end

	// Registered results drive the data and strobe outputs.
	assign acc        = acc_r;
	assign zero_flag  = zero_r;
	assign file_we    = we_r;
	assign file_wdata = wdata_r;

	// The port reads the decoded address while a word executes, else it shows the pending write address.
	// A write in the slot after a file-target word would land on the next word's address, hence the free slot.
	assign file_addr  = exec ? dec_addr : addr_r;

	// The idle slot also tells the core that the fetched word was dropped.
	assign idle_slot  = skip_r;
	assign busy       = skip_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// A skip word whose decremented value reaches zero.
	sequence s_skip_zero;
		exec && op == DCO_OP_DEC_SKIP && dec_byte(file_rdata) == '0;
	endsequence

	// A skip word whose decremented value stays nonzero.
	sequence s_skip_live;
		exec && op == DCO_OP_DEC_SKIP && dec_byte(file_rdata) != '0;
	endsequence

	// Exactly one idle slot, then execution resumes.
	sequence s_idle_once;
		idle_slot ##1 !idle_slot;
	endsequence

	// Complement: the result, its zero flag and where it lands.
	a_com_to_acc: assert property (@(posedge clk) disable iff (reset)
		exec && op == DCO_OP_COM && !to_file |=> acc == ~$past(file_rdata) && zero_flag == ($past(file_rdata) == 8'hFF))
		else $error("complement to accumulator wrong");

	a_com_to_file: assert property (@(posedge clk) disable iff (reset)
		exec && op == DCO_OP_COM && to_file |=> file_we && file_wdata == ~$past(file_rdata))
		else $error("complement write-back wrong");

	a_com_decode: assert property (@(posedge clk) disable iff (reset)
		exec && insn[13:8] == 6'h09 && insn[7] |=> file_we && addr_r == $past(insn[6:0]))
		else $error("complement decode wrong");

	a_com_keeps_acc: assert property (@(posedge clk) disable iff (reset)
		exec && op == DCO_OP_COM && to_file |=> $stable(acc) && zero_flag == ($past(file_rdata) == 8'hFF))
		else $error("complement write-back disturbed the accumulator");

	// Decrement: zero flag and both destinations.
	a_dec_zero: assert property (@(posedge clk) disable iff (reset)
		exec && op == DCO_OP_DEC |=> zero_flag == ($past(file_rdata) == 8'h01) && !idle_slot)
		else $error("decrement zero flag wrong");

	a_dec_to_acc: assert property (@(posedge clk) disable iff (reset)
		exec && op == DCO_OP_DEC && !to_file |=> acc == $past(file_rdata) - 8'h01 && !file_we)
		else $error("decrement to accumulator wrong");

	a_dec_to_file: assert property (@(posedge clk) disable iff (reset)
		exec && op == DCO_OP_DEC && to_file
		|=> file_we && file_wdata == $past(file_rdata) - 8'h01 && addr_r == $past(dec_addr))
		else $error("decrement write-back wrong");

	// Decrement with skip: flags untouched, routing and the idle slot.
	a_skip_flags: assert property (@(posedge clk) disable iff (reset)
		exec && op == DCO_OP_DEC_SKIP |=> $stable(zero_flag))
		else $error("skip variant changed zero flag");

	a_skip_route: assert property (@(posedge clk) disable iff (reset)
		exec && op == DCO_OP_DEC_SKIP && !to_file |=> acc == $past(file_rdata) - 8'h01 && !file_we)
		else $error("skip variant routing wrong");

	a_skip_to_file: assert property (@(posedge clk) disable iff (reset)
		exec && op == DCO_OP_DEC_SKIP && to_file
		|=> file_we && file_wdata == $past(file_rdata) - 8'h01 && addr_r == $past(dec_addr) && $stable(acc))
		else $error("skip variant write-back wrong");

	a_skip_discard: assert property (@(posedge clk) disable iff (reset)
		s_skip_zero |=> s_idle_once)
		else $error("skip did not discard next word");

	a_skip_single: assert property (@(posedge clk) disable iff (reset)
		s_skip_live |=> !idle_slot)
		else $error("skip without zero result took an idle slot");

	// Idle slot, write strobe, other words and reset.
	a_idle_quiet: assert property (@(posedge clk) disable iff (reset)
		idle_slot |=> !file_we && $stable(acc) && $stable(zero_flag))
		else $error("idle slot had an effect");

	a_write_taken: assert property (@(posedge clk) disable iff (reset)
		!exec |=> !file_we)
		else $error("file write without a taken word");

	a_other_quiet: assert property (@(posedge clk) disable iff (reset)
		exec && op == DCO_OP_NONE |=> !file_we && !idle_slot && $stable(acc) && $stable(zero_flag))
		else $error("other operation had an effect");

	a_reset_clear: assert property (@(posedge clk)
		reset |=> !idle_slot && !file_we && acc == ACC_RESET && zero_flag == ZERO_RESET)
		else $error("reset did not clear the execute state");
endmodule
`default_nettype wire

// File: verification/tb_dco_exec.sv
// Self-checking bench for the decrement and complement execute stage.
// Assumes dco_pkg is compiled first; the bench plays core fetch and file register.
`timescale 1ns/100ps
`default_nettype none
module tb_dco_exec import dco_pkg::*;;
	logic                clk        = 1'b0;
	logic                reset      = 1'b1;
	logic                insn_valid = 1'b0;
	logic [INSN_W-1:0]   insn       = 14'h0000;
	logic [DATA_W-1:0]   file_rdata = 8'h00;
	logic [ADDR_W-1:0]   file_addr;
	logic                file_we;
	logic [DATA_W-1:0]   file_wdata;
	logic [DATA_W-1:0]   acc;
	logic                zero_flag;
	logic                idle_slot;
	logic                busy;
	int                  n_fail     = 0;
	int                  cmp_count  = 0;

	// The clock runs at 125 MHz.
	always #4 clk = ~clk;

	dco_exec u_dco_exec (.clk(clk), .reset(reset), .insn_valid(insn_valid), .insn(insn),
		.file_rdata(file_rdata), .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata),
		.acc(acc), .zero_flag(zero_flag), .idle_slot(idle_slot), .busy(busy));

	// Compares one value and counts the result.
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Presents one word for one cycle, then leaves the core idle.
	task op(input logic [13:0] w, input logic [7:0] r);
		@(posedge clk);
		insn_valid <= 1'b1;
		insn <= w;
		file_rdata <= r;
		#1;
		chk("file_addr", {1'b0, w[6:0]}, {1'b0, file_addr});
		@(posedge clk);
		insn_valid <= 1'b0;
		#1;
	endtask

	// Checks the outputs just after reset is released.
	task t_reset;
		chk("acc", ACC_RESET, acc);
		chk("zero", {7'h00, ZERO_RESET}, {7'h00, zero_flag});
		chk("we", 8'h00, {7'h00, file_we});
		chk("idle", 8'h00, {7'h00, idle_slot});
	endtask

	// Complement to the accumulator and back into the file register.
	task t_com;
		op({OPC_COM, 1'b0, 7'h21}, 8'h13);
		chk("acc", 8'hEC, acc);
		chk("zero", 8'h00, {7'h00, zero_flag});
		op({OPC_COM, 1'b0, 7'h7F}, 8'hFF);
		chk("zero", 8'h01, {7'h00, zero_flag});
		op({OPC_COM, 1'b1, 7'h55}, 8'h0F);
		chk("addr", 8'h55, {1'b0, file_addr});
		chk("wdata", 8'hF0, file_wdata);
		chk("we", 8'h01, {7'h00, file_we});
		chk("acc", 8'h00, acc);
		@(posedge clk);
		#1;
		chk("we", 8'h00, {7'h00, file_we});
	endtask

	// Plain decrement, including the wrap from zero.
	task t_dec;
		op({OPC_DEC, 1'b0, 7'h03}, 8'h01);
		chk("zero", 8'h01, {7'h00, zero_flag});
		op({OPC_DEC, 1'b1, 7'h04}, 8'h00);
		chk("wdata", 8'hFF, file_wdata);
		chk("zero", 8'h00, {7'h00, zero_flag});
		chk("acc", 8'h00, acc);
		op({OPC_DEC, 1'b0, 7'h05}, 8'h01);
		chk("zero", 8'h01, {7'h00, zero_flag});
		chk("acc", 8'h00, acc);
	endtask

	// Skip variant with a nonzero result; the zero flag stays set.
	task t_skip_none;
		op({OPC_DEC_SKIP, 1'b0, 7'h06}, 8'h05);
		chk("acc", 8'h04, acc);
		chk("zero", 8'h01, {7'h00, zero_flag});
		chk("idle", 8'h00, {7'h00, idle_slot});
	endtask

	// Skip variant reaching zero; the word right behind it must be dropped.
	task t_skip_hit;
		@(posedge clk);
		insn_valid <= 1'b1;
		insn <= {OPC_DEC_SKIP, 1'b1, 7'h07};
		file_rdata <= 8'h01;
		@(posedge clk);
		insn <= {OPC_COM, 1'b0, 7'h08};
		file_rdata <= 8'h00;
		#1;
		chk("idle", 8'h01, {7'h00, idle_slot});
		chk("busy", 8'h01, {7'h00, busy});
		chk("wdata", 8'h00, file_wdata);
		chk("we", 8'h01, {7'h00, file_we});
		chk("addr", 8'h07, {1'b0, file_addr});
		chk("zero", 8'h01, {7'h00, zero_flag});
		@(posedge clk);
		insn_valid <= 1'b0;
		#1;
		chk("acc", 8'h04, acc);
		chk("idle", 8'h00, {7'h00, idle_slot});
	endtask

	// Words of other operations leave the write strobe, accumulator, zero flag and idle slot untouched.
	task t_other;
		op({6'h0F, 1'b1, 7'h09}, 8'hFF);
		chk("we", 8'h00, {7'h00, file_we});
		op({6'h0A, 1'b0, 7'h0A}, 8'h01);
		chk("acc", 8'h04, acc);
		chk("zero", 8'h01, {7'h00, zero_flag});
		chk("idle", 8'h00, {7'h00, idle_slot});
	endtask

	// A reset in the idle slot clears the results; the next word is taken normally.
	task t_reset_mid;
		op({OPC_COM, 1'b0, 7'h0C}, 8'h13);
		chk("acc", 8'hEC, acc);
		@(posedge clk);
		insn_valid <= 1'b1;
		insn <= {OPC_DEC_SKIP, 1'b1, 7'h0D};
		file_rdata <= 8'h01;
		@(posedge clk);
		insn_valid <= 1'b0;
		reset <= 1'b1;
		#1;
		chk("idle", 8'h01, {7'h00, idle_slot});
		@(posedge clk);
		reset <= 1'b0;
		#1;
		t_reset;
		op({OPC_DEC, 1'b0, 7'h0E}, 8'h03);
		chk("acc", 8'h02, acc);
		chk("zero", 8'h00, {7'h00, zero_flag});
	endtask

	// Prints the counts and the verdict, then ends the run.
	task stop_test;
		$display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence.
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		#1;
		t_reset;
		t_com;
		t_dec;
		t_skip_none;
		t_skip_hit;
		t_other;
		t_reset_mid;
		stop_test;
	end

	// Cuts a hung run short.
	initial begin
		#100000;
		n_fail++;
		stop_test;
	end
endmodule
`default_nettype wire
